// ===== design/mir_pkg.sv
/*
 * Constants, register map and carrier types for the metering interrupt
 * enable and status block (current channel A and voltage channel).
 * Assumes one core clock at 50 MHz and a metering datapath on that clock.
 */
// Overview of operation
// - Energy half-full events set flags 0 to 2
// - Overflow or underflow sets flags 3 to 5
// - No-load entry sets flags 6 to 8
// - Sign change of energy sets flags 9, 10
// - Missing current crossing past limit sets flag 11
// - Current channel A crossing sets flag 12
// - Current peak above threshold sets flag 13
// - Missing voltage crossing past limit sets flag 14
// - Voltage crossing sets flag 15
// - Voltage peak above threshold sets flag 16
// - New waveform sample set sets flag 17
// - Line cycle accumulation end sets flag 18
// - Voltage sag sets flag 19
// - Completed reset sequence sets flag 20
// - Reset-done interrupt can never be masked
// - Checksum change sets flag 21
// - Interrupt only where enable bit is one
// - Enable and status registers at two addresses
// - Mode bit 9 selects channel B apparent source
// - Active sign status bits 10 and 11
// - Reactive sign status bits 12 and 13
// - Live no-load state bits 16 to 21
package mir_pkg;

    // Register addresses, primary and alias
    localparam logic [9:0] ADDR_ACCMODE     = 10'h201;
    localparam logic [9:0] ADDR_ACCMODE_ALT = 10'h301;
    localparam logic [9:0] ADDR_IRQ_EN      = 10'h22c;
    localparam logic [9:0] ADDR_IRQ_EN_ALT  = 10'h32c;
    localparam logic [9:0] ADDR_STAT        = 10'h22d;
    localparam logic [9:0] ADDR_STAT_ALT    = 10'h32d;
    localparam logic [9:0] ADDR_STAT_CLR    = 10'h22e;
    localparam logic [9:0] ADDR_STAT_CLR_ALT = 10'h32e;
    localparam logic [9:0] ADDR_CROSS_LIMIT = 10'h0e0;
    localparam logic [9:0] ADDR_CUR_THRESH  = 10'h0e1;
    localparam logic [9:0] ADDR_VOLT_THRESH = 10'h0e2;

    // Flag positions in status and enable
    localparam int BIT_CROSS_TO_I = 11;
    localparam int BIT_CROSS_I    = 12;
    localparam int BIT_RESET_DONE = 20;
    localparam int BIT_CHECKSUM   = 21;

    // Field positions in the accumulation-mode register
    localparam int ACC_SRC_SEL_BIT = 9;
    localparam int ACC_SIGN_LSB    = 10;
    localparam int ACC_IDLE_LSB    = 16;

    // Masks and reset values
    localparam logic [31:0] EVT_MASK        = 32'h003f_ffff;
    localparam logic [31:0] EN_FORCED       = 32'h0010_0000;
    localparam logic [31:0] EN_RST          = 32'h0000_0000;
    localparam logic [9:0]  ACC_WR_RST      = 10'h000;
    localparam logic [15:0] CROSS_LIMIT_RST = 16'hffff;
    localparam logic [23:0] THRESH_RST      = 24'hff_ffff;

    // Timeout tick: one count of the crossing limit
    localparam int CLK_PERIOD_NS = 20;
    localparam int TICK_NS       = 1000;
    localparam int TICK_CYC      = TICK_NS / CLK_PERIOD_NS;

    // Register port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [9:0]  addr;
        logic [31:0] wdata;
    } mir_req_t;

    // Energy triple, active / reactive / apparent
    typedef struct packed {
        logic active;
        logic reactive;
        logic apparent;
    } mir_energy_t;

    // Signs of one channel
    typedef struct packed {
        logic active;
        logic reactive;
    } mir_sign_t;

    // One-cycle event pulses from the datapath
    typedef struct packed {
        mir_energy_t half;
        mir_energy_t wrap;
        logic        cross_i;
        logic        cross_v;
        logic        sample;
        logic        cycle_end;
        logic        sag;
        logic        soft_reset_done;
    } mir_evt_t;

    // Live levels from the datapath
    typedef struct packed {
        mir_energy_t idle_a;
        mir_energy_t idle_b;
        mir_sign_t   sign_a;
        mir_sign_t   sign_b;
        logic [23:0] peak_i;
        logic [23:0] peak_v;
        logic [31:0] checksum;
    } mir_lvl_t;

endpackage

// ===== design/mir_irq_status.sv
/*
 * Interrupt enable, sticky status and clearing logic for current channel A
 * and the voltage channel, plus the accumulation-mode status bits.
 * Assumes event pulses and levels come from logic on ref_clk, and that the
 * host port issues one-cycle read and write strobes.
 */
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none

module mir_irq_status
    import mir_pkg::*;
#(
    parameter int TICK_CYCLES = mir_pkg::TICK_CYC
) (
    input  wire logic              ref_clk,
    input  wire logic              reset,
    input  wire mir_pkg::mir_req_t req,
    output var  logic [31:0]       reg_rdata,
    input  wire mir_pkg::mir_evt_t evt,
    input  wire mir_pkg::mir_lvl_t lvl,
    output var  logic              chan_b_apparent_source_sel,
    output var  logic [8:0]        accum_mode,
    input  wire logic              irq_n_in,
    output var  logic              irq_n_out,
    output var  logic              irq_n_oe_n
);
    import mir_pkg::*;

    // Software state
    logic [31:0] enable_q;          // Interrupt enables
    logic [31:0] status_q;          // Sticky flags
    logic [31:0] status_d;
    logic [9:0]  acc_wr_q;          // Writable mode bits 9:0
    logic [15:0] cross_limit_q;     // Crossing timeout limit, in ticks
    logic [23:0] cur_thresh_q;      // Overcurrent level
    logic [23:0] volt_thresh_q;     // Overvoltage level
    logic [31:0] rdata_q;           // Read data, one cycle after strobe

    // Event detection state
    logic [31:0] evt_vec;           // One bit per flag source
    logic        boot_q;            // High for the cycle after reset
    mir_energy_t idle_a_q;          // Previous no-load levels
    mir_sign_t   sign_a_q;          // Previous signs
    logic        over_i_q;          // Previous overcurrent compare
    logic        over_v_q;          // Previous overvoltage compare
    logic [31:0] checksum_q;        // Last seen checksum
    logic        checksum_seen_q;   // Checksum has a reference
    logic        irq_q;             // Pin drive state

    // Crossing timeout machinery
    logic [15:0] tick_cnt_q;        // Tick prescaler
    logic        tick;
    logic [1:0]  cross_pulse;       // Bit 0 current, bit 1 voltage
    logic [1:0]  timeout_pulse;

    // Decoded strobes
    logic        wr_en;
    logic        wr_acc;
    logic        wr_limit;
    logic        wr_cthr;
    logic        wr_vthr;
    logic        rd_clear;
    logic [31:0] en_eff;
    logic [31:0] accmode_view;

    // Compares
    logic        over_i;
    logic        over_v;

    // Effective enables: reset-done always on
    assign en_eff = (enable_q & EVT_MASK) | EN_FORCED;

    // Write decode, either alias reaches the same register
    always_comb begin
        wr_en    = 1'b0;
        wr_acc   = 1'b0;
        wr_limit = 1'b0;
        wr_cthr  = 1'b0;
        wr_vthr  = 1'b0;
        if (req.wr && (req.addr == ADDR_IRQ_EN || req.addr == ADDR_IRQ_EN_ALT)) begin
            wr_en = 1'b1;
        end else if (req.wr && (req.addr == ADDR_ACCMODE || req.addr == ADDR_ACCMODE_ALT)) begin
            wr_acc = 1'b1;
        end else if (req.wr && req.addr == ADDR_CROSS_LIMIT) begin
            wr_limit = 1'b1;
        end else if (req.wr && req.addr == ADDR_CUR_THRESH) begin
            wr_cthr = 1'b1;
        end else if (req.wr && req.addr == ADDR_VOLT_THRESH) begin
            wr_vthr = 1'b1;
        end
    end

    // Clearing read, either alias
    assign rd_clear = req.rd && (req.addr == ADDR_STAT_CLR || req.addr == ADDR_STAT_CLR_ALT);

    // Enable register; bits above 21 never stored
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            enable_q <= EN_RST;
        end else if (wr_en) begin
            enable_q <= req.wdata & EVT_MASK;
        end
    end

    // Mode bits and the limit and threshold registers
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            acc_wr_q      <= ACC_WR_RST;
            cross_limit_q <= CROSS_LIMIT_RST;
            cur_thresh_q  <= THRESH_RST;
            volt_thresh_q <= THRESH_RST;
        end else begin
            if (wr_acc) begin
                acc_wr_q <= req.wdata[9:0];
            end
            if (wr_limit) begin
                cross_limit_q <= req.wdata[15:0];
            end
            if (wr_cthr) begin
                cur_thresh_q <= req.wdata[23:0];
            end
            if (wr_vthr) begin
                volt_thresh_q <= req.wdata[23:0];
            end
        end
    end

    // Mode outputs to the datapath
    assign chan_b_apparent_source_sel = acc_wr_q[ACC_SRC_SEL_BIT];
    assign accum_mode                 = acc_wr_q[8:0];

    // Accumulation-mode view: writable low bits, live status above
    always_comb begin
        accmode_view = 32'h0000_0000;
        accmode_view[9:0] = acc_wr_q;
        accmode_view[ACC_SIGN_LSB]     = lvl.sign_a.active;
        accmode_view[ACC_SIGN_LSB + 1] = lvl.sign_b.active;
        accmode_view[ACC_SIGN_LSB + 2] = lvl.sign_a.reactive;
        accmode_view[ACC_SIGN_LSB + 3] = lvl.sign_b.reactive;
        // Order here is active, apparent, reactive
        accmode_view[ACC_IDLE_LSB]     = lvl.idle_a.active;
        accmode_view[ACC_IDLE_LSB + 1] = lvl.idle_a.apparent;
        accmode_view[ACC_IDLE_LSB + 2] = lvl.idle_a.reactive;
        accmode_view[ACC_IDLE_LSB + 3] = lvl.idle_b.active;
        accmode_view[ACC_IDLE_LSB + 4] = lvl.idle_b.apparent;
        accmode_view[ACC_IDLE_LSB + 5] = lvl.idle_b.reactive;
    end

    // Read data: valid only in the cycle after the strobe, else zero
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdata_q <= 32'h0000_0000;
        end else if (!req.rd) begin
            rdata_q <= 32'h0000_0000;
        end else if (req.addr == ADDR_IRQ_EN || req.addr == ADDR_IRQ_EN_ALT) begin
            rdata_q <= en_eff;
        end else if (req.addr == ADDR_STAT || req.addr == ADDR_STAT_ALT) begin
            rdata_q <= status_q;
        end else if (rd_clear) begin
            rdata_q <= status_q;
        end else if (req.addr == ADDR_ACCMODE || req.addr == ADDR_ACCMODE_ALT) begin
            rdata_q <= accmode_view;
        end else if (req.addr == ADDR_CROSS_LIMIT) begin
            rdata_q <= {16'h0000, cross_limit_q};
        end else if (req.addr == ADDR_CUR_THRESH) begin
            rdata_q <= {8'h00, cur_thresh_q};
        end else if (req.addr == ADDR_VOLT_THRESH) begin
            rdata_q <= {8'h00, volt_thresh_q};
        end else begin
            // Unmapped reads return zero
            rdata_q <= 32'h0000_0000;
        end
    end
    assign reg_rdata = rdata_q;

    // Boot marker: raises reset-done once hardware reset is over
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            boot_q <= 1'b1;
        end else begin
            boot_q <= 1'b0;
        end
    end

    // Edge history for level sources
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            idle_a_q <= '0;
            sign_a_q <= '0;
            over_i_q <= 1'b0;
            over_v_q <= 1'b0;
        end else begin
            idle_a_q <= lvl.idle_a;
            sign_a_q <= lvl.sign_a;
            over_i_q <= over_i;
            over_v_q <= over_v;
        end
    end

    // Checksum reference; first sample after reset is not a change
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            checksum_q      <= 32'h0000_0000;
            checksum_seen_q <= 1'b0;
        end else begin
            checksum_q      <= lvl.checksum;
            checksum_seen_q <= 1'b1;
        end
    end

    // Peak compares; only the crossing into excess is an event
    assign over_i = lvl.peak_i > cur_thresh_q;
    assign over_v = lvl.peak_v > volt_thresh_q;

    // Tick prescaler for the crossing timeouts
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tick_cnt_q <= 16'h0000;
        end else if (tick) begin
            tick_cnt_q <= 16'h0000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 16'h0001;
        end
    end
    assign tick = tick_cnt_q == 16'(TICK_CYCLES - 1);

    assign cross_pulse = {evt.cross_v, evt.cross_i};

    // One timeout watcher per channel, same limit for both
    for (genvar ch = 0; ch < 2; ch++) begin : g_timeout
        logic [15:0] cnt_q;   // Ticks since last crossing
        logic        armed_q; // Waiting for a crossing or a timeout
        // Fires once per silence; a crossing rearms it
        always_ff @(posedge ref_clk) begin
            if (reset) begin
                cnt_q   <= 16'h0000;
                armed_q <= 1'b1;
            end else if (cross_pulse[ch]) begin
                cnt_q   <= 16'h0000;
                armed_q <= 1'b1;
            end else if (timeout_pulse[ch]) begin
                armed_q <= 1'b0;
            end else if (armed_q && tick) begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end
        assign timeout_pulse[ch] = armed_q && !cross_pulse[ch] &&
                                   (cnt_q >= cross_limit_q);
    end

    // Gather every flag source into one vector
    always_comb begin
        evt_vec = 32'h0000_0000;
        evt_vec[0]  = evt.half.active;
        evt_vec[1]  = evt.half.reactive;
        evt_vec[2]  = evt.half.apparent;
        evt_vec[3]  = evt.wrap.active;
        evt_vec[4]  = evt.wrap.reactive;
        evt_vec[5]  = evt.wrap.apparent;
        evt_vec[6]  = lvl.idle_a.active && !idle_a_q.active;
        evt_vec[7]  = lvl.idle_a.reactive && !idle_a_q.reactive;
        evt_vec[8]  = lvl.idle_a.apparent && !idle_a_q.apparent;
        // No sign history in the boot cycle, so a negative sign is no change
        evt_vec[9]  = !boot_q && (lvl.sign_a.active != sign_a_q.active);
        evt_vec[10] = !boot_q && (lvl.sign_a.reactive != sign_a_q.reactive);
        evt_vec[BIT_CROSS_TO_I] = timeout_pulse[0];
        evt_vec[BIT_CROSS_I]    = evt.cross_i;
        evt_vec[13] = over_i && !over_i_q;
        evt_vec[14] = timeout_pulse[1];
        evt_vec[15] = evt.cross_v;
        evt_vec[16] = over_v && !over_v_q;
        evt_vec[17] = evt.sample;
        evt_vec[18] = evt.cycle_end;
        evt_vec[19] = evt.sag;
        evt_vec[BIT_RESET_DONE] = boot_q || evt.soft_reset_done;
        evt_vec[BIT_CHECKSUM]   = checksum_seen_q &&
                                  (lvl.checksum != checksum_q);
    end

    // Sticky flags: an event in the clearing cycle wins over the clear
    always_comb begin
        status_d = status_q;
        if (rd_clear) begin
            status_d = 32'h0000_0000;
        end
        status_d = status_d | (evt_vec & EVT_MASK);
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            status_q <= 32'h0000_0000;
        end else begin
            status_q <= status_d;
        end
    end

    // Pin drive: pull low while any enabled flag is set
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_q & en_eff);
        end
    end

    // Open drain: value is always low, enable decides
    assign irq_n_out  = 1'b0;
    assign irq_n_oe_n = !irq_q;

    // Assertions

    sequence clear_read_s;
        req.rd && (req.addr == ADDR_STAT_CLR || req.addr == ADDR_STAT_CLR_ALT);
    endsequence

    sequence plain_read_s;
        req.rd && (req.addr == ADDR_STAT || req.addr == ADDR_STAT_ALT);
    endsequence

    sticky_flag_a: assert property (@(posedge ref_clk) disable iff (reset)
        (status_q[BIT_CROSS_I] && !rd_clear) |=> status_q[BIT_CROSS_I])
        else $error("status flag dropped without a clearing read");

    clear_read_a: assert property (@(posedge ref_clk) disable iff (reset)
        clear_read_s ##0 (evt_vec == 32'h0000_0000)
            |=> (reg_rdata == $past(status_q)) && (status_q == 32'h0000_0000))
        else $error("clearing read did not return then clear the flags");

    plain_read_a: assert property (@(posedge ref_clk) disable iff (reset)
        plain_read_s |=> (reg_rdata == $past(status_q)) &&
                         ((status_q & $past(status_q)) == $past(status_q)))
        else $error("plain status read changed or misreported flags");

    crossing_flag_a: assert property (@(posedge ref_clk) disable iff (reset)
        evt.cross_i |=> status_q[BIT_CROSS_I])
        else $error("current crossing did not set its flag");

    sign_change_a: assert property (@(posedge ref_clk) disable iff (reset)
        ($changed(lvl.sign_a.active) && !$past(reset)) |=> status_q[9])
        else $error("active sign change did not set its flag");

    reactive_sign_a: assert property (@(posedge ref_clk) disable iff (reset)
        ($changed(lvl.sign_a.reactive) && !$past(reset)) |=> status_q[10])
        else $error("reactive sign change did not set its flag");

    idle_entry_a: assert property (@(posedge ref_clk) disable iff (reset)
        ($rose(lvl.idle_a.reactive) && !$past(reset)) |=> status_q[7])
        else $error("reactive no-load entry did not set its flag");

    checksum_flag_a: assert property (@(posedge ref_clk) disable iff (reset)
        ($changed(lvl.checksum) && !$past(reset)) |=> status_q[BIT_CHECKSUM])
        else $error("checksum change did not set its flag");

    reset_done_a: assert property (@(posedge ref_clk)
        $fell(reset) |=> status_q[BIT_RESET_DONE] ##1 !irq_n_oe_n)
        else $error("reset-done flag or pin missing after reset");

    unmaskable_a: assert property (@(posedge ref_clk) disable iff (reset)
        status_q[BIT_RESET_DONE] |=> !irq_n_oe_n)
        else $error("reset-done flag did not drive the interrupt pin");

    pin_gate_a: assert property (@(posedge ref_clk) disable iff (reset)
        ((status_q & en_eff) == 32'h0000_0000) |=> irq_n_oe_n)
        else $error("interrupt pin driven with no enabled flag");

    peak_flag_a: assert property (@(posedge ref_clk) disable iff (reset)
        (over_i && !over_i_q) |=> status_q[13] && $rose(over_i_q))
        else $error("overcurrent did not set its flag");

    timeout_flag_a: assert property (@(posedge ref_clk) disable iff (reset)
        (g_timeout[0].armed_q && !evt.cross_i &&
         g_timeout[0].cnt_q >= cross_limit_q)
            |=> status_q[BIT_CROSS_TO_I] && !g_timeout[0].armed_q)
        else $error("current crossing timeout did not set its flag");

endmodule // mir_irq_status

`default_nettype wire

// ===== verification/mir_host.sv
/*
 * Host-side model of the register port and the interrupt pin wiring.
 * Assumes the block takes one-cycle strobes on ref_clk and answers a
 * read with data in the following cycle; the pin has a pull-up.
 */
`timescale 1ns/1ns
`default_nettype none

module mir_host
    import mir_pkg::*;
(
    input  wire logic              ref_clk,
    output var  mir_pkg::mir_req_t req,
    input  wire logic [31:0]       reg_rdata,
    input  wire logic              irq_n_out,
    input  wire logic              irq_n_oe_n,
    output wire logic              irq_line
);
    // Idle port at time zero
    initial begin
        req = '0;
    end

    // Pull-up wins while the block leaves the pin released
    assign irq_line = irq_n_oe_n ? 1'b1 : irq_n_out;

    // One write cycle; strobe dropped at the edge that takes it
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge ref_clk);
        req <= '0;
    endtask

    // One read cycle; data only stands in the cycle after the strobe
    task automatic rd(input logic [9:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge ref_clk);
        req <= '0;
        #1 d = reg_rdata;
    endtask
endmodule // mir_host

`default_nettype wire

// ===== verification/tb.sv
/*
 * Self-checking bench for the interrupt enable and status block.
 * Assumes the host model drives the register port and the bench drives
 * the datapath events and levels on ref_clk.
 */
`timescale 1ns/1ns
`default_nettype none

`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end

module tb
    import mir_pkg::*;
;
    logic        ref_clk;     // Core clock
    logic        reset;       // Synchronous reset
    mir_req_t    req;         // Host request
    logic [31:0] reg_rdata;   // Read data
    mir_evt_t    evt;         // Event pulses
    mir_lvl_t    lvl;         // Live levels
    logic        src_sel;     // Channel B apparent source
    logic [8:0]  acc_mode;    // Stored mode bits
    logic        irq_out;     // Pin value
    logic        irq_n_oe_n;  // Pin enable, low drives
    wire logic   irq_line;    // Resolved pin
    logic [31:0] rdat;        // Last read word
    int          num_errors;  // Mismatches
    int          checks_done; // Comparisons
    // Status bit for each event field, lsb field first
    int          evt_bit [12] = '{20, 19, 18, 17, 15, 12, 5, 4, 3, 2, 1, 0};

    // Short tick keeps the timeout test brief
    mir_irq_status #(.TICK_CYCLES(2)) i_mir_irq_status (
        .ref_clk(ref_clk), .reset(reset), .req(req), .reg_rdata(reg_rdata),
        .evt(evt), .lvl(lvl), .chan_b_apparent_source_sel(src_sel),
        .accum_mode(acc_mode), .irq_n_in(irq_line), .irq_n_out(irq_out),
        .irq_n_oe_n(irq_n_oe_n));

    mir_host i_mir_host (
        .ref_clk(ref_clk), .req(req), .reg_rdata(reg_rdata),
        .irq_n_out(irq_out), .irq_n_oe_n(irq_n_oe_n), .irq_line(irq_line));

    // 50 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // Verdict and end of run
    task automatic finish_test();
        if (num_errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Settle just past an edge so sampling never races the design
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // One-cycle event pulse
    task automatic pulse(input mir_evt_t e);
        @(posedge ref_clk);
        evt <= e;
        @(posedge ref_clk);
        evt <= '0;
    endtask

    // Hang guard, far beyond the few hundred cycles the run needs
    initial begin
        #400000;
        num_errors++;
        finish_test();
    end

    // Main sequence
    initial begin
        num_errors = 0;
        checks_done = 0;
        reset = 1'b1;
        evt = '0;
        lvl = '0;
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        wait_cyc(3);
        // Reset-done pending with every enable clear
        `CHK(irq_n_oe_n, 1'b0)
        `CHK(irq_line, 1'b0)
        i_mir_host.rd(ADDR_IRQ_EN, rdat);
        `CHK(rdat, 32'h0010_0000)
        i_mir_host.rd(ADDR_CROSS_LIMIT, rdat);
        `CHK(rdat, 32'h0000_ffff)
        i_mir_host.rd(ADDR_CUR_THRESH, rdat);
        `CHK(rdat, 32'h00ff_ffff)
        // Unmapped read and a write to the read-only status
        i_mir_host.rd(10'h3ff, rdat);
        `CHK(rdat, 32'h0)
        i_mir_host.wr(ADDR_STAT, 32'hffff_ffff);
        i_mir_host.rd(ADDR_STAT_ALT, rdat);
        `CHK(rdat, 32'h0010_0000)
        i_mir_host.rd(ADDR_STAT_CLR, rdat);
        `CHK(rdat, 32'h0010_0000)
        wait_cyc(2);
        `CHK(irq_n_oe_n, 1'b1)
        // Each event: sticky, plain read keeps, alias read clears
        for (int i = 0; i < 12; i++) begin
            pulse(mir_evt_t'(12'h1 << i));
            i_mir_host.rd(ADDR_STAT, rdat);
            `CHK(rdat, 32'h1 << evt_bit[i])
            i_mir_host.rd(ADDR_STAT_CLR_ALT, rdat);
            `CHK(rdat, 32'h1 << evt_bit[i])
            i_mir_host.rd(ADDR_STAT, rdat);
            `CHK(rdat, 32'h0)
        end
        // Enables: every other bit set leaves the pin released, except for reset-done
        for (int i = 0; i < 12; i++) begin
            i_mir_host.wr(ADDR_IRQ_EN_ALT, EVT_MASK & ~(32'h1 << evt_bit[i]));
            pulse(mir_evt_t'(12'h1 << i));
            wait_cyc(2);
            `CHK(irq_n_oe_n, (evt_bit[i] != 20))
            i_mir_host.wr(ADDR_IRQ_EN, 32'h1 << evt_bit[i]);
            i_mir_host.rd(ADDR_IRQ_EN_ALT, rdat);
            `CHK(rdat, (32'h1 << evt_bit[i]) | 32'h0010_0000)
            `CHK(irq_n_oe_n, 1'b0)
            i_mir_host.rd(ADDR_STAT_CLR, rdat);
            wait_cyc(2);
            `CHK(irq_n_oe_n, 1'b1)
        end
        // Mode bits and level-driven flags
        i_mir_host.wr(ADDR_ACCMODE, 32'h0000_03ff);
        i_mir_host.wr(ADDR_CUR_THRESH, 32'h100);
        i_mir_host.wr(ADDR_VOLT_THRESH, 32'h100);
        wait_cyc(1);
        `CHK(src_sel, 1'b1)
        `CHK(acc_mode, 9'h1ff)
        @(posedge ref_clk);
        lvl.peak_i <= 24'h100;
        lvl.peak_v <= 24'h100;
        wait_cyc(3);
        // A peak equal to the threshold is not above it
        i_mir_host.rd(ADDR_STAT_CLR, rdat);
        `CHK(rdat, 32'h0)
        @(posedge ref_clk);
        lvl <= '{idle_a: 3'b111, idle_b: 3'b101, sign_a: 2'b10, sign_b: 2'b01,
                 peak_i: 24'h101, peak_v: 24'h101, checksum: 32'h1};
        wait_cyc(3);
        i_mir_host.rd(ADDR_STAT_CLR, rdat);
        `CHK(rdat, 32'h0021_23c0)
        i_mir_host.rd(ADDR_ACCMODE_ALT, rdat);
        `CHK(rdat, 32'h001f_27ff)
        // Both signs flip and no-load is left: only the sign flags set
        @(posedge ref_clk);
        lvl.sign_a <= 2'b01;
        lvl.idle_a <= 3'b000;
        wait_cyc(3);
        i_mir_host.rd(ADDR_STAT_CLR, rdat);
        `CHK(rdat, 32'h0000_0600)
        // Crossing timeouts with a limit of three ticks
        i_mir_host.wr(ADDR_CROSS_LIMIT, 32'h3);
        wait_cyc(4);
        i_mir_host.rd(ADDR_STAT_CLR, rdat);
        pulse(mir_evt_t'(12'h030));
        i_mir_host.rd(ADDR_STAT, rdat);
        `CHK(rdat, 32'h0000_9000)
        wait_cyc(20);
        i_mir_host.rd(ADDR_STAT_CLR, rdat);
        `CHK(rdat, 32'h0000_d800)
        wait_cyc(20);
        // Fires once until the next crossing
        i_mir_host.rd(ADDR_STAT, rdat);
        `CHK(rdat, 32'h0)
        // Mid-run reset with a negative sign held: only reset-done returns
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        wait_cyc(3);
        `CHK(irq_n_oe_n, 1'b0)
        i_mir_host.rd(ADDR_STAT, rdat);
        `CHK(rdat, 32'h0010_0000)
        i_mir_host.rd(ADDR_IRQ_EN, rdat);
        `CHK(rdat, 32'h0010_0000)
        `CHK(src_sel, 1'b0)
        finish_test();
    end
endmodule // tb

`default_nettype wire
